// ### src/ubdt_idx_if.sv
// Interface carrying endpoint selection into the descriptor index calculator.
interface ubdt_idx_if;
	import ubdt_pkg::*;
	logic [3:0] endpoint;
	logic dirTx;
	logic odd;
	ubdt_pp_t ppMode;
	logic [5:0] index;
	modport calc (input endpoint, input dirTx, input odd, input ppMode,
		output index);
	modport user (output endpoint, output dirTx, output odd, output ppMode,
		input index);
endinterface

// ### src/ubdt_index_calc.sv
// Descriptor index from endpoint, direction and ping-pong mode.
module ubdt_index_calc
	import ubdt_pkg::*;
(
	ubdt_idx_if.calc sel
);
	logic [5:0] ep2;
	logic [5:0] ep4;
	logic [5:0] dirBit;
	logic [5:0] oddBit;

	// Index arithmetic is kept at six bits, enough for 64 descriptors.
	assign ep2 = {1'b0, sel.endpoint, 1'b0};
	assign ep4 = {sel.endpoint, 2'b00};
	assign dirBit = {5'h00, sel.dirTx};
	assign oddBit = {5'h00, sel.odd};

	// One case per ping-pong layout of the table.
	always_comb begin
		case (sel.ppMode)
			UBDT_PP_NONE: begin
				sel.index = ep2 + dirBit;
			end
			UBDT_PP_EP0RX: begin
				if (sel.endpoint == 4'h0) begin
					sel.index = sel.dirTx ? 6'h02 : oddBit;
				end else begin
					sel.index = ep2 + 6'h01 + dirBit;
				end
			end
			UBDT_PP_ALL: begin
				sel.index = ep4 + {dirBit[4:0], 1'b0} + oddBit;
			end
			UBDT_PP_NOTEP0: begin
				if (sel.endpoint == 4'h0) begin
					sel.index = dirBit;
				end else begin
					sel.index = ep4 - 6'h02 + {dirBit[4:0], 1'b0} + oddBit;
				end
			end
			default: begin
				sel.index = 6'h00;
			end
		endcase
	end
endmodule

// ### src/ubdt_pkg.sv
// Package with register map, field positions and reset values of the descriptor table block.
package ubdt_pkg;
	// Register byte offsets on the APB slave.
	localparam logic [7:0] UBDT_OFS_CONTROL = 8'h00;
	localparam logic [7:0] UBDT_OFS_OTG = 8'h04;
	localparam logic [7:0] UBDT_OFS_CONFIG = 8'h08;
	localparam logic [7:0] UBDT_OFS_BASE = 8'h0C;
	localparam logic [7:0] UBDT_OFS_TOKEN = 8'h10;
	localparam logic [7:0] UBDT_OFS_XSTAT = 8'h14;
	localparam logic [7:0] UBDT_OFS_POWER = 8'h18;
	localparam logic [7:0] UBDT_OFS_ENGINE = 8'h1C;

	// Field positions in usb_control.
	localparam int UBDT_CTL_MODEN = 0;
	localparam int UBDT_CTL_HOST = 3;
	// Field positions in otg_control.
	localparam int UBDT_OTG_DPUP = 7;
	localparam int UBDT_OTG_DPDN = 5;
	localparam int UBDT_OTG_DMDN = 4;
	localparam int UBDT_OTG_OVREN = 2;
	// Field position in the power register.
	localparam int UBDT_PWR_ON = 0;
	// Endpoint field of usb_transfer_status, bits 7 to 4.
	localparam int UBDT_XST_EP_LSB = 4;
	localparam int UBDT_XST_DIR = 3;
	localparam int UBDT_XST_ODD = 2;

	// Reset values.
	localparam logic [7:0] UBDT_RST_CONTROL = 8'h00;
	localparam logic [7:0] UBDT_RST_OTG = 8'h00;
	localparam logic [1:0] UBDT_RST_CONFIG = 2'h0;
	localparam logic [7:0] UBDT_RST_BASE = 8'h00;
	localparam logic [3:0] UBDT_RST_TOKEN = 4'h0;
	localparam logic [7:0] UBDT_RST_XSTAT = 8'h00;

	// Descriptor layout: 4 bytes each, status word then buffer address.
	localparam int UBDT_TABLE_ALIGN_BITS = 9;
	localparam logic [15:0] UBDT_ADDR_WORD_OFS = 16'h0002;
	localparam int UBDT_OWN_BIT = 15;
	localparam int UBDT_DTS_BIT = 14;

	// Ping-pong modes of usb_config_one bits 1:0.
	typedef enum logic [1:0] {
		UBDT_PP_NONE = 2'b00,
		UBDT_PP_EP0RX = 2'b01,
		UBDT_PP_ALL = 2'b10,
		UBDT_PP_NOTEP0 = 2'b11
	} ubdt_pp_t;

	// Descriptor engine states.
	typedef enum logic [2:0] {
		UBDT_ST_IDLE = 3'b000,
		UBDT_ST_RDSTAT = 3'b001,
		UBDT_ST_RDADDR = 3'b010,
		UBDT_ST_WRSTAT = 3'b011,
		UBDT_ST_DONE = 3'b100
	} ubdt_state_t;
endpackage

// ### src/usb_buffer_descriptor_table.sv
// Descriptor table engine, pull resistor control and APB register file.
//
// How it works
// - Table is a 512-byte aligned RAM block; addresses assume that.
// - Table location comes only from the table base pointer upper byte.
// - Descriptor is two 16-bit words: status, then buffer address.
// - Up to 64 descriptors, index 0 to 63.
// - Buffer addresses are 16 bits, so only the lowest 64 Kbytes.
// - Table spans at most 256 bytes, at least eight bytes.
// - Index chosen from endpoint, direction and ping-pong field.
// - Host mode always uses endpoint 0 descriptors and control.
// - Host mode reports remote source endpoint in status bits 7:4.
// - Host mode addresses transmits to the token register endpoint.
// - Owner flag clear means CPU owns; set means module owns.
// - Status word reads are allowed to both parties at any time.
// - Status word has two layouts; owner flag (bit 15) and byte count (bits 9:0) are shared.
// - Module writes token PID and actual byte count into status.
// - Pull-downs follow host enable, or OTG bits 5:4 under override.
// - Suspend never releases the device pull-up.
// - D+ pull-up follows enable and power, or OTG bit 7 on override.
// - D+ pull-up is forced off below the session-valid threshold.
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
module usb_buffer_descriptor_table
	import ubdt_pkg::*;
(
	input wire logic mclk,
	input wire logic sys_rst,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Serial engine side, same clock.
	input wire logic engFetch,
	input wire logic engComplete,
	input wire logic [3:0] engEndpoint,
	input wire logic engDirTx,
	input wire logic engOdd,
	input wire logic [3:0] engPid,
	input wire logic engDts,
	input wire logic [9:0] engByteCount,
	output logic engDone,
	output logic engOwned,
	output logic [15:0] engBufAddr,
	output logic [9:0] engMaxCount,
	output logic [3:0] tokenEndpoint,
	output logic hostMode,
	// Data RAM port, 16-bit words.
	output logic memReq,
	output logic memWrite,
	output logic [15:0] memAddr,
	output logic [15:0] memWdata,
	input wire logic memAck,
	input wire logic [15:0] memRdata,
	// Pins and pull resistor controls.
	input wire logic vbusSessionValid,
	output logic dplusPullup,
	output logic dplusPulldown,
	output logic dminusPulldown
);
	logic [7:0] usbControl_q;
	logic [7:0] otgControl_q;
	logic [1:0] configOne_q;
	logic [7:0] tableBase_q;
	logic [3:0] tokenReg_q;
	logic [7:0] xferStatus_q;
	logic modulePower_q;
	logic vbusMeta_q;
	logic vbusSync_q;
	ubdt_state_t state_q;
	logic opComplete_q;
	logic [3:0] opEndpoint_q;
	logic opDirTx_q;
	logic opOdd_q;
	logic [3:0] opPid_q;
	logic opDts_q;
	logic [9:0] opCount_q;
	logic [15:0] descAddr_q;
	logic engDone_q;
	logic engOwned_q;
	logic [15:0] engBufAddr_q;
	logic [9:0] engMaxCount_q;
	logic [31:0] prdata_q;
	logic apbSetup;
	logic apbWrite;
	logic addrHit;
	logic [31:0] readMux;
	logic [15:0] tableOrigin;
	logic [15:0] descAddr_d;
	logic overrideEn;
	logic startOp;

	ubdt_idx_if idxBus ();

	// Zero-wait slave; unmapped offsets answer with an error.
	assign apbSetup = psel && !penable;
	assign apbWrite = psel && penable && pwrite && addrHit;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addrHit;
	assign prdata = prdata_q;

	// Decode of the implemented offsets.
	always_comb begin
		case (paddr)
			UBDT_OFS_CONTROL, UBDT_OFS_OTG, UBDT_OFS_CONFIG,
			UBDT_OFS_BASE, UBDT_OFS_TOKEN, UBDT_OFS_XSTAT,
			UBDT_OFS_POWER, UBDT_OFS_ENGINE: begin
				addrHit = 1'b1;
			end
			default: begin
				addrHit = 1'b0;
			end
		endcase
	end

	// Read data is chosen here and held in a flop for the access phase.
	always_comb begin
		case (paddr)
			UBDT_OFS_CONTROL: readMux = {24'h00_0000, usbControl_q};
			UBDT_OFS_OTG: readMux = {24'h00_0000, otgControl_q};
			UBDT_OFS_CONFIG: readMux = {30'h0000_0000, configOne_q};
			UBDT_OFS_BASE: readMux = {24'h00_0000, tableBase_q};
			UBDT_OFS_TOKEN: readMux = {28'h000_0000, tokenReg_q};
			UBDT_OFS_XSTAT: readMux = {24'h00_0000, xferStatus_q};
			UBDT_OFS_POWER: readMux = {31'h0000_0000, modulePower_q};
			UBDT_OFS_ENGINE: readMux = {28'h000_0000, engOwned_q,
				state_q};
			default: readMux = 32'h0000_0000;
		endcase
	end

	// Read data is latched in the setup cycle so it is stable in access.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			prdata_q <= 32'h0000_0000;
		end else if (apbSetup) begin
			prdata_q <= readMux;
		end
	end

	// Control registers written by software.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			usbControl_q <= UBDT_RST_CONTROL;
			otgControl_q <= UBDT_RST_OTG;
			configOne_q <= UBDT_RST_CONFIG;
			modulePower_q <= 1'b0;
		end else if (apbWrite) begin
			case (paddr)
				UBDT_OFS_CONTROL: usbControl_q <= pwdata[7:0];
				UBDT_OFS_OTG: otgControl_q <= pwdata[7:0];
				UBDT_OFS_CONFIG: configOne_q <= pwdata[1:0];
				UBDT_OFS_POWER: modulePower_q <= pwdata[UBDT_PWR_ON];
				default: begin
				end
			endcase
		end
	end

	// The base pointer alone places the table in RAM.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			tableBase_q <= UBDT_RST_BASE;
		end else if (apbWrite && paddr == UBDT_OFS_BASE) begin
			tableBase_q <= pwdata[7:0];
		end
	end

	// Destination endpoint for host transmits.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			tokenReg_q <= UBDT_RST_TOKEN;
		end else if (apbWrite && paddr == UBDT_OFS_TOKEN) begin
			tokenReg_q <= pwdata[3:0];
		end
	end

	assign hostMode = usbControl_q[UBDT_CTL_HOST];
	assign tokenEndpoint = tokenReg_q;

	// The session-valid comparator output is a pin, so it is synchronised.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			vbusMeta_q <= 1'b0;
			vbusSync_q <= 1'b0;
		end else begin
			vbusMeta_q <= vbusSessionValid;
			vbusSync_q <= vbusMeta_q;
		end
	end

	// Pull resistors. Suspend has no input here on purpose: the pull-up
	// must stay on through suspend, so nothing in suspend may drop it.
	assign overrideEn = otgControl_q[UBDT_OTG_OVREN];
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			dplusPullup <= 1'b0;
			dplusPulldown <= 1'b0;
			dminusPulldown <= 1'b0;
		end else begin
			// Below session valid the pull-up is forced off.
			if (!vbusSync_q) begin
				dplusPullup <= 1'b0;
			end else if (overrideEn) begin
				dplusPullup <= otgControl_q[UBDT_OTG_DPUP];
			end else begin
				dplusPullup <= usbControl_q[UBDT_CTL_MODEN] &&
					modulePower_q;
			end
			if (overrideEn) begin
				dplusPulldown <= otgControl_q[UBDT_OTG_DPDN];
				dminusPulldown <= otgControl_q[UBDT_OTG_DMDN];
			end else begin
				dplusPulldown <= hostMode;
				dminusPulldown <= hostMode;
			end
		end
	end

	// In host mode every transfer is mapped onto endpoint 0.
	assign idxBus.endpoint = hostMode ? 4'h0 : engEndpoint;
	assign idxBus.dirTx = engDirTx;
	assign idxBus.odd = engOdd;
	assign idxBus.ppMode = ubdt_pp_t'(configOne_q);

	ubdt_index_calc idxCalc (
		.sel(idxBus.calc)
	);

	// The table origin drops the low pointer bit: the table is 512-byte
	// aligned, so no carry out of the descriptor offset is possible.
	assign tableOrigin = {tableBase_q[7:1], {UBDT_TABLE_ALIGN_BITS{1'b0}}};
	assign descAddr_d = tableOrigin | {8'h00, idxBus.index, 2'b00};

	assign startOp = state_q == UBDT_ST_IDLE && (engFetch || engComplete);

	// Request capture; the engine handles one operation at a time and
	// ignores new strobes until it has returned to idle.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			opComplete_q <= 1'b0;
			opEndpoint_q <= 4'h0;
			opDirTx_q <= 1'b0;
			opOdd_q <= 1'b0;
			opPid_q <= 4'h0;
			opDts_q <= 1'b0;
			opCount_q <= 10'h000;
			descAddr_q <= 16'h0000;
		end else if (startOp) begin
			opComplete_q <= engComplete;
			opEndpoint_q <= engEndpoint;
			opDirTx_q <= engDirTx;
			opOdd_q <= engOdd;
			opPid_q <= engPid;
			opDts_q <= engDts;
			opCount_q <= engByteCount;
			descAddr_q <= descAddr_d;
		end
	end

	// Engine sequence: a fetch reads status, then the buffer address if the module owns it; a
	// completion rewrites the status word and hands ownership back.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state_q <= UBDT_ST_IDLE;
		end else begin
			case (state_q)
				UBDT_ST_IDLE: begin
					if (engComplete) begin
						state_q <= UBDT_ST_WRSTAT;
					end else if (engFetch) begin
						state_q <= UBDT_ST_RDSTAT;
					end
				end
				UBDT_ST_RDSTAT: begin
					if (memAck) begin
						// A descriptor the CPU owns is left untouched.
						state_q <= memRdata[UBDT_OWN_BIT] ?
							UBDT_ST_RDADDR : UBDT_ST_DONE;
					end
				end
				UBDT_ST_RDADDR: begin
					if (memAck) begin
						state_q <= UBDT_ST_DONE;
					end
				end
				UBDT_ST_WRSTAT: begin
					if (memAck) begin
						state_q <= UBDT_ST_DONE;
					end
				end
				UBDT_ST_DONE: begin
					state_q <= UBDT_ST_IDLE;
				end
				default: begin
					state_q <= UBDT_ST_IDLE;
				end
			endcase
		end
	end

	// RAM port. Requests hold until acknowledged; the status word sits at
	// the descriptor address and the buffer address word two bytes on.
	always_comb begin
		memReq = 1'b0;
		memWrite = 1'b0;
		memAddr = descAddr_q;
		memWdata = 16'h0000;
		case (state_q)
			UBDT_ST_RDSTAT: begin
				memReq = 1'b1;
			end
			UBDT_ST_RDADDR: begin
				memReq = 1'b1;
				memAddr = descAddr_q + UBDT_ADDR_WORD_OFS;
			end
			UBDT_ST_WRSTAT: begin
				memReq = 1'b1;
				memWrite = 1'b1;
				// Module layout of the status word; owner flag cleared
				// so the CPU regains the descriptor.
				memWdata = {1'b0, opDts_q, opPid_q, opCount_q};
			end
			default: begin
			end
		endcase
	end

	// Results of a fetch, held until the next operation.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			engOwned_q <= 1'b0;
			engMaxCount_q <= 10'h000;
			engBufAddr_q <= 16'h0000;
		end else if (memAck && state_q == UBDT_ST_RDSTAT) begin
			engOwned_q <= memRdata[UBDT_OWN_BIT];
			engMaxCount_q <= memRdata[9:0];
		end else if (memAck && state_q == UBDT_ST_RDADDR) begin
			// Full 16-bit word: reach is the lowest 64 Kbytes.
			engBufAddr_q <= memRdata;
		end else if (memAck && state_q == UBDT_ST_WRSTAT) begin
			engOwned_q <= 1'b0;
		end
	end

	// One-cycle done pulse after each operation.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			engDone_q <= 1'b0;
		end else begin
			engDone_q <= state_q == UBDT_ST_DONE;
		end
	end

	assign engDone = engDone_q;
	assign engOwned = engOwned_q;
	assign engBufAddr = engBufAddr_q;
	assign engMaxCount = engMaxCount_q;

	// Transfer status after a completion. In host mode the endpoint field
	// reports the remote endpoint, not the endpoint 0 slot used.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			xferStatus_q <= UBDT_RST_XSTAT;
		end else if (memAck && state_q == UBDT_ST_WRSTAT) begin
			xferStatus_q[7:UBDT_XST_EP_LSB] <= opEndpoint_q;
			xferStatus_q[UBDT_XST_DIR] <= opDirTx_q;
			xferStatus_q[UBDT_XST_ODD] <= opOdd_q;
			xferStatus_q[1:0] <= 2'b00;
		end
	end
endmodule

// ### tb/ubdt_ram_model.sv
// Data RAM partner for the descriptor engine, with optional wait states.
module ubdt_ram_model (
	input wire logic mclk,
	input wire logic slow,
	input wire logic memReq,
	input wire logic memWrite,
	input wire logic [15:0] memAddr,
	input wire logic [15:0] memWdata,
	output logic memAck,
	output logic [15:0] memRdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] mem [0:1023];
	logic [1:0] waitQ;
	// Slow mode stalls each access two cycles to stress the request hold.
	assign memAck = memReq && (!slow || waitQ == 2'h2);
	// Outside an acknowledge the data lines carry garbage, not the word.
	assign memRdata = memAck ? mem[memAddr[10:1]] : ~mem[memAddr[10:1]];
	// Status words stay readable at any moment, owned or not.
	always @(posedge mclk) begin
		waitQ <= (memReq && !memAck) ? waitQ + 2'h1 : 2'h0;
		if (memAck && memWrite) begin
			mem[memAddr[10:1]] <= memWdata;
		end
	end
endmodule

// ### tb/ubdt_sva.sv
// Checker for table addressing, write-back and pull resistor outputs.
module ubdt_sva
	import ubdt_pkg::*;
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic engDone,
	input wire logic hostMode,
	input wire logic memReq,
	input wire logic memWrite,
	input wire logic memAck,
	input wire logic [15:0] memAddr,
	input wire logic [15:0] memWdata,
	input wire logic vbusSessionValid,
	input wire logic dplusPullup,
	input wire logic dplusPulldown,
	input wire logic dminusPulldown
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] ctlQ, otgQ, baseQ;
	logic pwrQ, ovr, upX, dpX, dmX;
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	// Shadow copies of the registers, taken from completed writes.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			{ctlQ, otgQ, baseQ, pwrQ} <= '0;
		end else if (psel && penable && pwrite) begin
			case (paddr)
				UBDT_OFS_CONTROL: ctlQ <= pwdata[7:0];
				UBDT_OFS_OTG: otgQ <= pwdata[7:0];
				UBDT_OFS_BASE: baseQ <= pwdata[7:0];
				UBDT_OFS_POWER: pwrQ <= pwdata[0];
				default: ;
			endcase
		end
	end
	// Override hands all three resistors to the OTG bits.
	assign ovr = otgQ[UBDT_OTG_OVREN];
	assign upX = ovr ? otgQ[UBDT_OTG_DPUP] : ctlQ[UBDT_CTL_MODEN] && pwrQ;
	assign dpX = ovr ? otgQ[UBDT_OTG_DPDN] : ctlQ[UBDT_CTL_HOST];
	assign dmX = ovr ? otgQ[UBDT_OTG_DMDN] : ctlQ[UBDT_CTL_HOST];
	a_dplus_down: assert property (dplusPulldown == $past(dpX))
		else $error("D+ pull-down wrong");
	a_dminus_down: assert property (dminusPulldown == $past(dmX))
		else $error("D- pull-down wrong");
	a_pullup_lost: assert property (
		!vbusSessionValid [*4] |-> !dplusPullup)
		else $error("D+ pull-up on without VBUS");
	a_pullup_on: assert property (
		vbusSessionValid [*4] |-> dplusPullup == $past(upX))
		else $error("D+ pull-up wrong");
	a_table_base: assert property (
		memReq |-> memAddr[15:9] == baseQ[7:1] && !memAddr[8] && !memAddr[0])
		else $error("descriptor access outside the table");
	a_host_ep0: assert property (
		memReq && hostMode |-> memAddr[8:4] == 5'h00)
		else $error("host mode used a non-zero endpoint slot");
	a_owner_clear: assert property (
		memReq && memWrite |-> !memWdata[UBDT_OWN_BIT])
		else $error("write-back left the owner flag set");
	a_req_hold: assert property (
		memReq && !memAck |=> memReq && $stable(memAddr) && $stable(memWrite))
		else $error("memory request dropped or changed");
	a_done_bound: assert property ($rose(memReq) |-> ##[1:16] engDone)
		else $error("engine did not finish");
	c_slow_mem: cover property (memReq && !memAck);
	c_write_back: cover property (memWrite && memAck);
	c_host_done: cover property (engDone && hostMode);
endmodule
bind usb_buffer_descriptor_table ubdt_sva i_ubdt_sva (.*);

// ### tb/usb_buffer_descriptor_table_tb.sv
// Bench: registers, pull controls, descriptor index map and write-back.
module usb_buffer_descriptor_table_tb
	import ubdt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, slow = 0;
	logic engFetch = 0, engComplete = 0, engDirTx = 0, engOdd = 0, engDts = 0;
	logic vbusSessionValid = 0, pready, pslverr, engDone, engOwned, hostMode;
	logic memReq, memWrite, memAck, dplusPullup, dplusPulldown, dminusPulldown;
	logic [3:0] engEndpoint = 0, engPid = 0, tokenEndpoint;
	logic [7:0] paddr = 0;
	logic [9:0] engByteCount = 0, engMaxCount;
	logic [15:0] engBufAddr, memAddr, memWdata, memRdata;
	logic [31:0] pwdata = 0, prdata;
	int fail_count = 0, compares = 0;
	usb_buffer_descriptor_table i_usb_buffer_descriptor_table (.*);
	ubdt_ram_model i_ubdt_ram_model (.*);
	// System clock, 100 ns period.
	always #50 mclk = ~mclk;
	// Compare one result and count it.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %h, expected %h", $time, got, exp);
		end
	endtask
	// Counts and verdict; the only exit of the run.
	task automatic print_verdict();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// A wait that runs out counts as a mismatch and ends the run.
	task automatic hung();
		fail_count++;
		$display("wrong value at %0t: wait ran out", $time);
		print_verdict();
	endtask
	// APB transfer; the request is held until pready is sampled high.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) hung();
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge mclk);
	endtask
	// Register write.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1, a, d, r, e);
	endtask
	// Register read, judging data and error response.
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] r;
		logic e;
		apb(0, a, 32'h0000_0000, r, e);
		chk(r, x);
		chk({31'h0, e}, {31'h0, xe});
	endtask
	// One-cycle engine strobe, then a bounded wait for the done pulse.
	task automatic eng(input logic c, input logic [3:0] ep, input logic t,
		input logic o, input logic [9:0] n);
		int k;
		engFetch <= !c;
		engComplete <= c;
		engEndpoint <= ep;
		engDirTx <= t;
		engOdd <= o;
		engByteCount <= n;
		engPid <= n[3:0] ^ 4'hA;
		engDts <= ~n[0];
		@(posedge mclk);
		engFetch <= 0;
		engComplete <= 0;
		k = 0;
		do begin
			@(negedge mclk);
			k++;
		end while (engDone !== 1'b1 && k < 20);
		if (engDone !== 1'b1) hung();
		@(posedge mclk);
	endtask
	// Expected slot per mode, written out by hand so that it does not echo
	// the index arithmetic: endpoints 0, 1 and 15, each as RX even, RX odd,
	// TX even and TX odd.
	localparam int IDX_TBL[48] = '{
		0, 0, 1, 1, 2, 2, 3, 3, 30, 30, 31, 31,
		0, 1, 2, 2, 3, 3, 4, 4, 31, 31, 32, 32,
		0, 1, 2, 3, 4, 5, 6, 7, 60, 61, 62, 63,
		0, 0, 1, 1, 2, 3, 4, 5, 58, 59, 60, 61};
	// Reset values, an unmapped offset and a read-only register.
	task automatic t_regs();
		for (int a = 0; a < 32; a += 4) begin
			rd(8'(a), 32'h0000_0000, 0);
		end
		rd(8'h20, 32'h0000_0000, 1);
		wr(UBDT_OFS_XSTAT, 32'h0000_00FF);
		rd(UBDT_OFS_XSTAT, 32'h0000_0000, 0);
	endtask
	// Pull levels for enable, host, override bits and lost VBUS.
	task automatic t_pulls();
		logic [7:0] c[5] = '{8'h01, 8'h08, 8'h09, 8'h00, 8'h00};
		logic [7:0] o[5] = '{8'h00, 8'h00, 8'h04, 8'hA4, 8'h94};
		logic [2:0] x[5] = '{3'b100, 3'b011, 3'b000, 3'b110, 3'b101};
		vbusSessionValid <= 1;
		wr(UBDT_OFS_POWER, 32'h0000_0001);
		for (int i = 0; i < 5; i++) begin
			wr(UBDT_OFS_CONTROL, {24'h0, c[i]});
			wr(UBDT_OFS_OTG, {24'h0, o[i]});
			repeat (2) @(posedge mclk);
			chk({dplusPullup, dplusPulldown, dminusPulldown}, x[i]);
		end
		vbusSessionValid <= 0;
		repeat (4) @(posedge mclk);
		chk(dplusPullup, 0);
		wr(UBDT_OFS_OTG, 32'h0000_0000);
		wr(UBDT_OFS_CONTROL, 32'h0000_0000);
	endtask
	// Every ping-pong mode over edge endpoints; mode 2 meets a slow RAM.
	task automatic t_index();
		logic [3:0] ep;
		logic [5:0] x;
		wr(UBDT_OFS_BASE, 32'h0000_0003);
		for (int m = 0; m < 4; m++) begin
			wr(UBDT_OFS_CONFIG, 32'(m));
			slow <= (m == 2);
			for (int k = 0; k < 12; k++) begin
				ep = k < 4 ? 4'h0 : (k < 8 ? 4'h1 : 4'hF);
				x = 6'(IDX_TBL[12 * m + k]);
				eng(0, ep, k[1], k[0], 10'h000);
				chk(engBufAddr, 16'hFFC0 | 16'(x));
				chk(engMaxCount, 10'(x));
				chk(engOwned, 1);
			end
		end
		slow <= 0;
	endtask
	// Host mode: endpoint 0 slots, token target and source report.
	task automatic t_host();
		wr(UBDT_OFS_CONFIG, 32'h0000_0000);
		wr(UBDT_OFS_CONTROL, 32'h0000_0008);
		wr(UBDT_OFS_TOKEN, 32'h0000_0009);
		@(posedge mclk);
		chk(tokenEndpoint, 4'h9);
		chk(hostMode, 1);
		eng(1, 4'h5, 1, 0, 10'h2A5);
		chk(i_ubdt_ram_model.mem[258], 16'h3EA5);
		rd(UBDT_OFS_XSTAT, 32'h0000_0058, 0);
		eng(0, 4'h7, 1, 0, 10'h000);
		chk(engOwned, 0);
		eng(1, 4'h3, 0, 1, 10'h001);
		chk(i_ubdt_ram_model.mem[256], 16'h2C01);
		rd(UBDT_OFS_XSTAT, 32'h0000_0034, 0);
	endtask
	// Table filled before reset ends, so every slot starts owned by the module.
	initial begin
		for (int n = 0; n < 64; n++) begin
			i_ubdt_ram_model.mem[256 + 2 * n] = 16'h8000 | 16'(n);
			i_ubdt_ram_model.mem[257 + 2 * n] = 16'hFFC0 | 16'(n);
		end
		repeat (6) @(posedge mclk);
		sys_rst <= 0;
		@(posedge mclk);
		t_regs();
		t_pulls();
		t_index();
		t_host();
		print_verdict();
	end
endmodule
